// ==== hw/uvps_stage.sv ====
// one undervoltage stage: selection, comparator, blocking, timer, outputs
// assumes settings held stable by the parent and one eval pulse per update
`timescale 1ns/1ps
`include "uvps_consts.svh"
module uvps_stage (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// evaluation
	input wire logic eval,
	input wire logic [`UVPS_VW-1:0] mag_a,
	input wire logic [`UVPS_VW-1:0] mag_b,
	input wire logic [`UVPS_VW-1:0] mag_c,
	input wire logic use_c,
	input wire logic ext_block,
	// settings
	input wire logic [`UVPS_VW-1:0] pick_level,
	input wire logic [`UVPS_VW-1:0] block_level,
	input wire uvps_pkg::uvps_delay_type delay_mode,
	input wire logic [`UVPS_TW-1:0] delay_ticks,
	input wire uvps_pkg::uvps_force_type force_sel,
	input wire logic force_en,
	// outputs
	output logic start,
	output logic trip,
	output logic blocked,
	output logic [`UVPS_VW-1:0] low_mag
);
	uvps_pkg::uvps_state_type st_r, st_nxt;
	logic [`UVPS_TW-1:0] tmr_r, tmr_nxt;
	logic inhibit_r, inhibit_nxt;
	logic [`UVPS_VW+6:0] rel_lvl;
	logic [`UVPS_VW+6:0] lo_scaled;
	logic [`UVPS_VW-1:0] lo_ab;
	logic below, above_rel, all_above, below_blk, blk_on, due;
	logic [`UVPS_TW-1:0] idmt_ticks;

	// ----------------------------------------
	// comparator
	// ----------------------------------------
	assign lo_ab = (mag_a < mag_b) ? mag_a : mag_b;
	assign low_mag = (use_c && mag_c < lo_ab) ? mag_c : lo_ab;
	assign below = low_mag < pick_level; // R23
	assign rel_lvl = 23'(pick_level) * 23'(`UVPS_HYST_NUM);
	assign lo_scaled = 23'(low_mag) * 23'(`UVPS_HYST_DEN);
	assign above_rel = lo_scaled >= rel_lvl; // R19
	assign all_above = (mag_a > pick_level) && (mag_b > pick_level) && (!use_c || mag_c > pick_level);
	assign below_blk = (block_level != '0) && (low_mag < block_level); // R21
	assign inhibit_nxt = (block_level == '0) ? 1'b0 : (below_blk ? 1'b1 : (all_above ? 1'b0 : inhibit_r));
	assign blk_on = ext_block || inhibit_nxt; // R3
	// inverse time: deeper sag trips sooner, scaled by depth ratio
	assign idmt_ticks = (pick_level == '0) ? delay_ticks :
		16'(({16'h0, delay_ticks} * {16'h0, low_mag}) / {16'h0, pick_level});
	assign due = (delay_mode == uvps_pkg::uvps_dly_instant) ||
		(delay_mode == uvps_pkg::uvps_dly_idmt ? tmr_r >= idmt_ticks : tmr_r >= delay_ticks); // R5

	// ----------------------------------------
	// state machine, stepped once per update
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		unique case (st_r)
			uvps_pkg::uvps_st_idle: begin
				tmr_nxt = '0;
				if (below && blk_on) begin
					st_nxt = uvps_pkg::uvps_st_blocked; // R20
				end else if (below) begin
					st_nxt = (delay_mode == uvps_pkg::uvps_dly_instant) ? uvps_pkg::uvps_st_trip
						: uvps_pkg::uvps_st_start; // R7
				end
			end
			uvps_pkg::uvps_st_start: begin
				tmr_nxt = tmr_r + 16'h1;
				if (blk_on || above_rel) begin
					st_nxt = uvps_pkg::uvps_st_idle; // R20
				end else if (due) begin
					st_nxt = uvps_pkg::uvps_st_trip;
				end
			end
			uvps_pkg::uvps_st_trip: begin
				if (above_rel || blk_on) begin
					st_nxt = uvps_pkg::uvps_st_idle;
				end
			end
			uvps_pkg::uvps_st_blocked: begin
				if (above_rel || !blk_on) begin
					st_nxt = uvps_pkg::uvps_st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= uvps_pkg::uvps_st_idle;
			tmr_r <= '0;
			inhibit_r <= 1'b0;
		end else if (eval) begin // R22
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			inhibit_r <= inhibit_nxt;
		end
	end

	// ----------------------------------------
	// outputs with forcing
	// ----------------------------------------
	always_comb begin
		start = (st_r == uvps_pkg::uvps_st_start) || (st_r == uvps_pkg::uvps_st_trip);
		trip = st_r == uvps_pkg::uvps_st_trip;
		blocked = st_r == uvps_pkg::uvps_st_blocked;
		if (force_en && force_sel != uvps_pkg::uvps_frc_normal) begin // R17
			start = (force_sel == uvps_pkg::uvps_frc_start) || (force_sel == uvps_pkg::uvps_frc_trip);
			trip = force_sel == uvps_pkg::uvps_frc_trip;
			blocked = force_sel == uvps_pkg::uvps_frc_blocked;
		end
	end

	trip_needs_start_a: assert property (@(posedge clk) disable iff (!rst_n) trip |-> start) // R7
		else $error("trip without start");
	block_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!force_en && blocked) |-> !start) // R20
		else $error("blocked with start");
	hold_between_a: assert property (@(posedge clk) disable iff (!rst_n)
		!eval |=> $stable(st_r)) // R22
		else $error("state moved off update");
endmodule

// ==== hw/uvps_top.sv ====
// undervoltage protection: four stages, AXI4-Lite settings, events, counters
// assumes RMS magnitudes arrive from logic on clk with a one-cycle update strobe
`timescale 1ns/1ps
`include "uvps_consts.svh"
// Notes on behaviour
// R1: four independent stages, each with own settings, outputs and events.
// R2: each stage uses line or phase voltages as selected.
// R3: blocking from internal low-voltage level or an external block input.
// R4: eight setting groups chosen by one shared selector.
// R5: instant operation, or delayed by definite time or inverse time.
// R6: start, trip, blocked outputs, each with stamped on and off events.
// R7: instant mode raises start and trip together, same stamp.
// R8: event stamps count in one millisecond steps.
// R9: separate start, trip, blocked counters, clearable by software.
// R10: inputs are three line and three phase rms values every 5 ms.
// R11: prefault value is a 20 ms average ending 20 ms before the event.
// R12: input select 0 line, 1 phase, 2 channel three, 3 channel four; default 0.
// R13: line and phase use first three channels, first two in two-line mode.
// R14: channel three selection works only in two-line mode.
// R15: channel four selection monitors channel four.
// R16: general settings ignore the setting group.
// R17: force 0 normal 1 start 2 trip 3 blocked, only when forcing enabled.
// R18: group and block changes take effect live, no restart.
// R19: release when voltage exceeds 103 percent of pick-up.
// R20: block at pick-up gives blocked; block releases an active start.
// R21: below nonzero block level, inhibit until all lines exceed pick-up.
// R22: evaluate once per measurement update with latest values.
// R23: pick up when any selected voltage falls below the pick-up level.
module uvps_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// measurements
	input wire logic meas_update,
	input wire logic [`UVPS_VW-1:0] line_voltage_ab,
	input wire logic [`UVPS_VW-1:0] line_voltage_bc,
	input wire logic [`UVPS_VW-1:0] line_voltage_ca,
	input wire logic [`UVPS_VW-1:0] phase_voltage_a,
	input wire logic [`UVPS_VW-1:0] phase_voltage_b,
	input wire logic [`UVPS_VW-1:0] phase_voltage_c,
	input wire logic [`UVPS_VW-1:0] chan3_voltage,
	input wire logic [`UVPS_VW-1:0] chan4_voltage,
	input wire logic two_line_mode,
	input wire logic [3:0] ext_block,
	// outputs
	output logic [3:0] stage_start,
	output logic [3:0] stage_trip,
	output logic [3:0] stage_blocked,
	// events
	output logic evt_valid,
	output logic [1:0] evt_stage,
	output logic [2:0] evt_on,
	output logic [2:0] evt_off,
	output logic [31:0] evt_stamp
);
	logic [2:0] grp_r;
	logic force_en_r;
	logic [31:0] ms_r;
	logic [16:0] div_r;
	logic ms_tick;
	logic [1:0] sel_r [4];
	logic [1:0] force_r [4];
	logic [1:0] dmode_r [4];
	logic [`UVPS_VW-1:0] pick_r [32];
	logic [`UVPS_VW-1:0] blk_r [32];
	logic [`UVPS_TW-1:0] time_r [32];
	logic [`UVPS_CW-1:0] cnt_r [12];
	logic [2:0] prev_r [4];
	logic [`UVPS_VW-1:0] hist_r [4][8];
	logic [`UVPS_VW-1:0] pre_r [4];
	logic [`UVPS_VW-1:0] low_mag [4];
	logic [`UVPS_VW-1:0] sa [4];
	logic [`UVPS_VW-1:0] sb [4];
	logic [`UVPS_VW-1:0] sc [4];
	logic use_c [4];
	logic [2:0] cur [4];
	logic [2:0] rise [4];
	logic [2:0] fall [4];
	logic [11:0] aw_r, ar_r;
	logic aw_ok_r, w_ok_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic wr_go, rd_go;
	logic [31:0] rd_val;
	logic rd_hit, wr_hit;

	function automatic logic [4:0] slot(input logic [11:0] a);
		slot = a[6:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				merge[i*8 +: 8] = d[i*8 +: 8];
			end
		end
	endfunction

	// ----------------------------------------
	// millisecond time stamp
	// ----------------------------------------
	assign ms_tick = div_r == 17'(`UVPS_MS_CYC - 1);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= '0;
			ms_r <= '0;
		end else begin
			div_r <= ms_tick ? 17'h0 : div_r + 17'h1;
			ms_r <= ms_r + {31'h0, ms_tick}; // R8
		end
	end

	// ----------------------------------------
	// stages
	// ----------------------------------------
	for (genvar s = 0; s < `UVPS_STAGES; s++) begin : g_stage // R1
		logic [4:0] idx;
		assign idx = {2'(s), grp_r}; // R4
		always_comb begin
			use_c[s] = !two_line_mode; // R13
			sa[s] = line_voltage_ab;
			sb[s] = line_voltage_bc;
			sc[s] = line_voltage_ca;
			unique case (uvps_pkg::uvps_sel_type'(sel_r[s])) // R2
				uvps_pkg::uvps_sel_pp: begin
				end
				uvps_pkg::uvps_sel_pe: begin
					sa[s] = phase_voltage_a;
					sb[s] = phase_voltage_b;
					sc[s] = phase_voltage_c;
				end
				uvps_pkg::uvps_sel_ch3: begin
					// channel three only in two-line mode, else held healthy
					sa[s] = two_line_mode ? chan3_voltage : '1; // R14
					sb[s] = sa[s];
					use_c[s] = 1'b0;
				end
				uvps_pkg::uvps_sel_ch4: begin
					sa[s] = chan4_voltage; // R15
					sb[s] = chan4_voltage;
					use_c[s] = 1'b0;
				end
			endcase
		end
		uvps_stage u_stage (
			.clk(clk),
			.rst_n(rst_n),
			.eval(meas_update), // R10
			.mag_a(sa[s]),
			.mag_b(sb[s]),
			.mag_c(sc[s]),
			.use_c(use_c[s]),
			.ext_block(ext_block[s]), // R18
			.pick_level(pick_r[idx]),
			.block_level(blk_r[idx]),
			.delay_mode(uvps_pkg::uvps_delay_type'(dmode_r[s])),
			.delay_ticks(time_r[idx]),
			.force_sel(uvps_pkg::uvps_force_type'(force_r[s])),
			.force_en(force_en_r),
			.start(stage_start[s]),
			.trip(stage_trip[s]),
			.blocked(stage_blocked[s]),
			.low_mag(low_mag[s])
		);
		assign cur[s] = {stage_blocked[s], stage_trip[s], stage_start[s]};
		assign rise[s] = cur[s] & ~prev_r[s];
		assign fall[s] = prev_r[s] & ~cur[s];
	end

	// ----------------------------------------
	// events, counters, prefault history
	// ----------------------------------------
	logic [1:0] evt_pick;
	logic evt_any;
	always_comb begin
		evt_pick = 2'h0;
		evt_any = 1'b0;
		for (int s = 3; s >= 0; s--) begin
			if (rise[s] != 3'h0 || fall[s] != 3'h0) begin
				evt_pick = 2'(s);
				evt_any = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evt_valid <= 1'b0;
			evt_stage <= '0;
			evt_on <= '0;
			evt_off <= '0;
			evt_stamp <= '0;
			for (int s = 0; s < 4; s++) begin
				prev_r[s] <= '0;
				pre_r[s] <= '0;
				for (int k = 0; k < 8; k++) begin
					hist_r[s][k] <= '0;
				end
			end
		end else begin
			evt_valid <= evt_any;
			evt_stage <= evt_pick;
			evt_on <= rise[evt_pick]; // R6 R7
			evt_off <= fall[evt_pick];
			evt_stamp <= ms_r;
			prev_r[evt_pick] <= cur[evt_pick];
			for (int s = 0; s < 4; s++) begin
				if (meas_update) begin
					hist_r[s][0] <= low_mag[s];
					for (int k = 1; k < 8; k++) begin
						hist_r[s][k] <= hist_r[s][k-1];
					end
				end
				if (s == int'(evt_pick) && evt_any && (rise[s][0] || rise[s][1])) begin
					// samples 4..7 span the 20 ms ending 20 ms back
					pre_r[s] <= 16'((18'(hist_r[s][4]) + 18'(hist_r[s][5]) + 18'(hist_r[s][6])
						+ 18'(hist_r[s][7])) >> 2); // R11
				end
			end
		end
	end

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
	assign s_axi_wready = !w_ok_r && !s_axi_bvalid;
	assign wr_go = aw_ok_r && w_ok_r;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign wr_hit = aw_r[11:8] <= 4'h3;
	assign rd_hit = s_axi_araddr[11:8] <= 4'h3;

	always_comb begin
		rd_val = 32'h0;
		unique case (s_axi_araddr[11:8])
			4'h0: begin
				if (s_axi_araddr[7:0] == `UVPS_REG_CTRL) rd_val = {31'h0, force_en_r};
				else if (s_axi_araddr[7:0] == `UVPS_REG_GROUP) rd_val = {29'h0, grp_r};
				else if (s_axi_araddr[7:0] == `UVPS_REG_STATUS)
					rd_val = {20'h0, stage_blocked, stage_trip, stage_start};
				else if (s_axi_araddr[7:0] == `UVPS_REG_MILLIS) rd_val = ms_r;
				else if (s_axi_araddr[7:4] == 4'h1)
					rd_val = {26'h0, dmode_r[s_axi_araddr[3:2]], force_r[s_axi_araddr[3:2]],
						sel_r[s_axi_araddr[3:2]]};
				else if (s_axi_araddr[7:5] == 3'h1 && s_axi_araddr[4:2] < 3'h6)
					rd_val = {cnt_r[{s_axi_araddr[4:2], 1'b0}], cnt_r[{s_axi_araddr[4:2], 1'b1}]};
				else if (s_axi_araddr[7:4] == 4'h5) rd_val = {16'h0, pre_r[s_axi_araddr[3:2]]};
			end
			4'h1: rd_val = {16'h0, pick_r[slot(s_axi_araddr)]};
			4'h2: rd_val = {16'h0, blk_r[slot(s_axi_araddr)]};
			4'h3: rd_val = {16'h0, time_r[slot(s_axi_araddr)]};
			default: rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			aw_r <= '0;
			wd_r <= '0;
			ws_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_r <= 1'b1;
				aw_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// settings and counters
	// ----------------------------------------
	logic [31:0] wm;
	assign wm = merge(32'h0, wd_r, ws_r);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			grp_r <= '0;
			force_en_r <= 1'b0;
			for (int s = 0; s < 4; s++) begin
				sel_r[s] <= 2'h0; // R12
				force_r[s] <= 2'h0;
				dmode_r[s] <= 2'h1;
			end
			for (int i = 0; i < 32; i++) begin
				pick_r[i] <= `UVPS_PICK_RST;
				blk_r[i] <= `UVPS_BLK_RST;
				time_r[i] <= `UVPS_TIME_RST;
			end
			for (int i = 0; i < 12; i++) begin
				cnt_r[i] <= '0;
			end
		end else begin
			for (int s = 0; s < 4; s++) begin
				for (int k = 0; k < 3; k++) begin
					if (s == int'(evt_pick) && evt_any && rise[s][k]) begin
						cnt_r[s*3+k] <= cnt_r[s*3+k] + 16'h1; // R9
					end
				end
			end
			if (wr_go && aw_r[11:8] == 4'h0) begin
				if (aw_r[7:0] == `UVPS_REG_CTRL) begin
					force_en_r <= wm[0];
					if (wm[1]) begin
						for (int i = 0; i < 12; i++) begin
							cnt_r[i] <= '0; // R9
						end
					end
				end
				if (aw_r[7:0] == `UVPS_REG_GROUP) grp_r <= wm[2:0]; // R18
				if (aw_r[7:4] == 4'h1) begin // R16
					sel_r[aw_r[3:2]] <= wm[1:0];
					force_r[aw_r[3:2]] <= wm[3:2];
					dmode_r[aw_r[3:2]] <= wm[5:4];
				end
			end
			if (wr_go && aw_r[11:8] == 4'h1) pick_r[slot(aw_r)] <= 16'(merge(32'(pick_r[slot(aw_r)]), wd_r, ws_r));
			if (wr_go && aw_r[11:8] == 4'h2) blk_r[slot(aw_r)] <= 16'(merge(32'(blk_r[slot(aw_r)]), wd_r, ws_r));
			if (wr_go && aw_r[11:8] == 4'h3) time_r[slot(aw_r)] <= 16'(merge(32'(time_r[slot(aw_r)]), wd_r, ws_r));
		end
	end

	bresp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("bvalid dropped");
	ms_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_n && !ms_tick) |=> (div_r == $past(div_r) + 17'h1) && (ms_r == $past(ms_r))) // R8
		else $error("stamp moved between ticks");
	force_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		(force_en_r && force_r[3] == 2'h2) |-> (stage_trip[3] && stage_start[3] && !stage_blocked[3])) // R17
		else $error("forced trip not shown");
endmodule

// ==== pkg/uvps_consts.svh ====
// constants of the undervoltage protection stage: offsets, fields, resets, timing
// assumes inclusion by bare name from design and bench files
`ifndef UVPS_CONSTS_SVH
`define UVPS_CONSTS_SVH
// ----------------------------------------
// geometry
// ----------------------------------------
`define UVPS_STAGES 4
`define UVPS_GROUPS 8
`define UVPS_VW 16
`define UVPS_TW 16
`define UVPS_CW 16
// ----------------------------------------
// register offsets (bytes); setting word at base + 4*(stage*8+group)
// ----------------------------------------
`define UVPS_REG_CTRL 12'h000
`define UVPS_REG_GROUP 12'h004
`define UVPS_REG_STATUS 12'h008
`define UVPS_REG_MILLIS 12'h00c
`define UVPS_REG_GEN 12'h010
`define UVPS_REG_CNT 12'h020
`define UVPS_REG_EVT 12'h040
`define UVPS_REG_PRE 12'h050
`define UVPS_REG_PICK 12'h100
`define UVPS_REG_BLK 12'h200
`define UVPS_REG_TIME 12'h300
// ----------------------------------------
// reset values
// ----------------------------------------
`define UVPS_PICK_RST 16'h1770
`define UVPS_BLK_RST 16'h03e8
`define UVPS_TIME_RST 16'h0008
// ----------------------------------------
// timing
// ----------------------------------------
`define UVPS_CLK_HZ 125000000
`define UVPS_MS_NS 1000000
`define UVPS_CLK_NS 8
`define UVPS_MS_CYC (`UVPS_MS_NS / `UVPS_CLK_NS)
`define UVPS_TICK_MS 5
`define UVPS_AVG_SAMPLES 4
`define UVPS_HYST_NUM 103
`define UVPS_HYST_DEN 100
`endif

// ==== pkg/uvps_pkg.sv ====
// types of the undervoltage protection stage
// assumes uvps_consts.svh on the include path
package uvps_pkg;
	typedef enum logic [1:0] {
		uvps_sel_pp = 2'h0,
		uvps_sel_pe = 2'h1,
		uvps_sel_ch3 = 2'h2,
		uvps_sel_ch4 = 2'h3
	} uvps_sel_type;
	typedef enum logic [1:0] {
		uvps_frc_normal = 2'h0,
		uvps_frc_start = 2'h1,
		uvps_frc_trip = 2'h2,
		uvps_frc_blocked = 2'h3
	} uvps_force_type;
	typedef enum logic [1:0] {
		uvps_dly_instant = 2'h0,
		uvps_dly_dt = 2'h1,
		uvps_dly_idmt = 2'h2
	} uvps_delay_type;
	typedef enum logic [1:0] {
		uvps_st_idle = 2'h0,
		uvps_st_start = 2'h1,
		uvps_st_trip = 2'h2,
		uvps_st_blocked = 2'h3
	} uvps_state_type;
endpackage

// ==== verification/tb_top.sv ====
// self-checking bench: axi4-lite register calls and measurement scenarios
// assumes the measurement model and the stage top on one clock
`timescale 1ns/1ps
`include "uvps_consts.svh"
module tb_top;
	logic clk = 0, rst_n = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, evt_stage;
	logic [31:0] s_axi_rdata, evt_stamp, rd_d;
	logic [1:0] rd_r, wr_r;
	logic meas_update, two_line_mode = 0, evt_valid;
	logic [15:0] line_voltage_ab, line_voltage_bc, line_voltage_ca, chan3_voltage, chan4_voltage;
	logic [15:0] phase_voltage_a, phase_voltage_b, phase_voltage_c, lvl = 16'h2710, lvl4 = 16'h2710;
	logic [3:0] ext_block = 0, stage_start, stage_trip, stage_blocked;
	logic [2:0] evt_on, evt_off, ev0 = 0, ev0_off = 0;
	int fails = 0, n_tests = 0, cyc = 0;
	always #4 clk = ~clk;
	uvps_meas_model #(.PER(40)) PARTNER (.clk, .rst_n, .lvl, .lvl4, .meas_update, .line_voltage_ab,
		.line_voltage_bc, .line_voltage_ca, .phase_voltage_a, .phase_voltage_b, .phase_voltage_c,
		.chan3_voltage, .chan4_voltage);
	uvps_top DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.meas_update, .line_voltage_ab, .line_voltage_bc, .line_voltage_ca, .phase_voltage_a,
		.phase_voltage_b, .phase_voltage_c, .chan3_voltage, .chan4_voltage, .two_line_mode, .ext_block,
		.stage_start, .stage_trip, .stage_blocked, .evt_valid, .evt_stage, .evt_on, .evt_off, .evt_stamp);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			finish_test;
		end
	end
	// first on event and latest off event of stage 0 kept for comparison
	always @(posedge clk) begin
		if (evt_valid === 1'b1 && evt_stage === 2'h0 && ev0 === 3'h0) ev0 <= evt_on;
		if (evt_valid === 1'b1 && evt_stage === 2'h0 && evt_off !== 3'h0) ev0_off <= evt_off;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		wr_r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	task upd(input int n);
		repeat (n) @(posedge meas_update);
		repeat (2) @(posedge clk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`UVPS_REG_STATUS);
		chk(rd_d, 32'h0);
		rd(`UVPS_REG_PICK);
		chk(rd_d, 32'h1770);
		rd(`UVPS_REG_GEN);
		chk(rd_d, 32'h10);
		rd(12'h400);
		chk(rd_r, 2'h2);
		wr(12'h400, 32'h1);
		chk(wr_r, 2'h2);
		wr(`UVPS_REG_GROUP, 32'h1);
		chk(wr_r, 2'h0);
		wr(`UVPS_REG_PICK + 12'h004, 32'h0800);
		wr(`UVPS_REG_GEN, 32'h0);
		rd(`UVPS_REG_GEN);
		chk(rd_d, 32'h0);
		lvl <= 16'd5000;
		upd(2);
		chk(stage_start, 4'he);
		chk(stage_trip, 4'h0);
		lvl <= 16'd1500;
		upd(2);
		chk(stage_start, 4'hf);
		chk(stage_trip, 4'h1);
		chk(ev0, 3'h3);
		upd(9);
		chk(stage_trip, 4'hf);
		lvl <= 16'd6100;
		upd(2);
		chk(stage_start, 4'he);
		chk(ev0_off, 3'h3);
		lvl <= 16'd6200;
		upd(2);
		chk(stage_start, 4'h0);
		rd(`UVPS_REG_CNT);
		chk(rd_d, 32'h00010001);
		wr(`UVPS_REG_CTRL, 32'h2);
		rd(`UVPS_REG_CNT);
		chk(rd_d, 32'h0);
		rd(`UVPS_REG_MILLIS);
		chk(rd_d, 32'h0);
		chk(evt_stamp, 32'h0);
		ext_block <= 4'h4;
		lvl <= 16'd5000;
		upd(2);
		chk(stage_blocked, 4'h4);
		chk(stage_start, 4'ha);
		ext_block <= 4'h0;
		lvl <= 16'd6200;
		upd(2);
		lvl <= 16'd500;
		upd(12);
		chk(stage_trip, 4'h0);
		chk(stage_blocked, 4'hf);
		lvl <= 16'd6200;
		upd(2);
		wr(`UVPS_REG_GEN + 12'h008, 32'h13);
		lvl4 <= 16'd3000;
		upd(2);
		chk(stage_start, 4'h4);
		wr(`UVPS_REG_GEN + 12'h00c, 32'h18);
		repeat (2) @(posedge clk);
		chk(stage_trip[3], 1'b0);
		wr(`UVPS_REG_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk(stage_trip[3], 1'b1);
		finish_test;
	end
endmodule

// ==== verification/uvps_meas_model.sv ====
// measurement front end model: rms magnitudes with a periodic update strobe
// assumes one clock shared with the stage; levels are set by the bench
`timescale 1ns/1ps
module uvps_meas_model #(
	parameter int PER = 40
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wanted levels
	input wire logic [15:0] lvl,
	input wire logic [15:0] lvl4,
	// measurements
	output logic meas_update,
	output logic [15:0] line_voltage_ab,
	output logic [15:0] line_voltage_bc,
	output logic [15:0] line_voltage_ca,
	output logic [15:0] phase_voltage_a,
	output logic [15:0] phase_voltage_b,
	output logic [15:0] phase_voltage_c,
	output logic [15:0] chan3_voltage,
	output logic [15:0] chan4_voltage
);
	int cnt;
	assign line_voltage_bc = 16'h2710;
	assign line_voltage_ca = 16'h2710;
	assign phase_voltage_a = 16'h2710;
	assign phase_voltage_b = 16'h2710;
	assign phase_voltage_c = 16'h2710;
	assign chan3_voltage = 16'h2710;
	// magnitudes change only together with the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= 0;
			meas_update <= 1'b0;
			line_voltage_ab <= 16'h2710;
			chan4_voltage <= 16'h2710;
		end else begin
			meas_update <= (cnt == PER - 1);
			cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
			if (cnt == PER - 1) begin
				line_voltage_ab <= lvl;
				chan4_voltage <= lvl4;
			end
		end
	end
endmodule
